// *** hw/imst_cfg.svh ***
// register offsets, field positions, reset values and masks of the interrupt miss block
`ifndef IMST_CFG_SVH
`define IMST_CFG_SVH
// ****************************************
// register byte addresses
// ****************************************
`define IMST_FLAG_IDX 16'h4600
`define IMST_MISS_IDX 16'h4602
`define IMST_TRIG_IDX 16'h4638
`define IMST_STAT_IDX 16'h4640
`define IMST_MASK_IDX 16'h4642
// ****************************************
// field positions
// ****************************************
`define IMST_BIT_WDOG 15
`define IMST_BIT_FAULT 14
`define IMST_BIT_TMR 13
`define IMST_BIT_GPIO 12
`define IMST_BIT_ADC 11
`define IMST_BIT_LRX 10
`define IMST_BIT_LTX 9
`define IMST_BIT_LTMR 8
`define IMST_BIT_SEC 7
`define IMST_BIT_SC2 6
`define IMST_BIT_SC1 5
`define IMST_BIT_SLEEP 4
`define IMST_BIT_BB 3
`define IMST_BIT_DBG 2
`define IMST_BIT_SW 1
`define IMST_BIT_STAT_MISS 0
`define IMST_BIT_STAT_TRIG 1
// ****************************************
// masks and reset values
// ****************************************
`define IMST_MISS_USED 16'hFFFE
`define IMST_MISS_FREE 16'h3860
`define IMST_FLAG_PROT 16'h0010
`define IMST_RST_MISS 16'h0000
`define IMST_RST_FLAG 16'h0000
`define IMST_RST_TRIG 16'h0000
`define IMST_RST_STAT 2'h0
`define IMST_RST_MASK 2'h0
`endif

// *** hw/imst_pkg.sv ***
// types shared by the interrupt miss block
package imst_pkg;
	typedef logic [15:0] imst_word_t;
	typedef logic [1:0] imst_ev_t;
endpackage

// *** hw/imst_top.sv ***
// interrupt miss tracking, pending flags and software trigger with avalon-mm slave
`include "imst_cfg.svh"
module imst_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// avalon-mm slave
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [15:0] avs_writedata,
	input wire logic [1:0] avs_byteenable,
	output logic [15:0] avs_readdata,
	output logic avs_waitrequest,
	// mode and sources
	input wire logic app_mode,
	input wire imst_pkg::imst_word_t source_event,
	// results
	output imst_pkg::imst_word_t pending_flags,
	output logic soft_irq_source,
	output logic irq
);
	import imst_pkg::*;

	// ****************************************
	// synchronisers for pins
	// ****************************************
	logic app_mode_s1;
	logic app_mode_s2;
	imst_word_t ev_s1;
	imst_word_t ev_s2;
	imst_word_t ev_prev;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			app_mode_s1 <= 1'b0;
			app_mode_s2 <= 1'b0;
			ev_s1 <= 16'h0000;
			ev_s2 <= 16'h0000;
			ev_prev <= 16'h0000;
		end else begin
			app_mode_s1 <= app_mode;
			app_mode_s2 <= app_mode_s1;
			ev_s1 <= source_event;
			ev_s2 <= ev_s1;
			ev_prev <= ev_s2;
		end
	end

	// ****************************************
	// bus decode
	// ****************************************
	// one wait cycle per access: waitrequest drops the cycle after the request appears
	logic ack;
	wire req = (avs_read | avs_write) & ~ack;
	// writes commit at the edge where the master samples waitrequest low
	wire do_wr = avs_write & ack;
	wire do_rd = avs_read & ~ack;
	wire imst_word_t be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire sel_flag = avs_address == `IMST_FLAG_IDX;
	wire sel_miss = avs_address == `IMST_MISS_IDX;
	wire sel_trig = avs_address == `IMST_TRIG_IDX;
	wire sel_stat = avs_address == `IMST_STAT_IDX;
	wire sel_mask = avs_address == `IMST_MASK_IDX;

	imst_word_t miss;
	imst_word_t flag;
	imst_word_t trig;
	imst_ev_t stat;
	imst_ev_t mask;

	// ****************************************
	// source edges and write masks
	// ****************************************
	wire trig_wr = do_wr & sel_trig & (|avs_byteenable);
	// software source fires from the trigger; hardware sources on rising edges
	wire imst_word_t new_ev = ((ev_s2 & ~ev_prev) | {14'h0000, trig_wr, 1'b0})
		& `IMST_MISS_USED;
	// bits writable now: in app mode only the free group of miss, and every used flag bit except the protected one
	wire imst_word_t miss_wmask = (app_mode_s2 ? `IMST_MISS_FREE : `IMST_MISS_USED)
		& be_mask;
	wire imst_word_t flag_wmask = (app_mode_s2 ? ~`IMST_FLAG_PROT : `IMST_MISS_USED)
		& `IMST_MISS_USED & be_mask;
	wire miss_wr = do_wr & sel_miss;
	wire flag_wr = do_wr & sel_flag;
	// a new event while still pending is a miss; set wins over a clearing write
	wire imst_word_t miss_set = new_ev & flag;
	wire imst_word_t next_miss = (miss_wr ? ((miss & ~miss_wmask) | (avs_writedata & miss_wmask))
		: miss) | miss_set;
	wire imst_word_t next_flag = (flag_wr ? ((flag & ~flag_wmask) | (avs_writedata & flag_wmask))
		: flag) | new_ev;
	wire imst_word_t next_trig = trig_wr ? ((trig & ~be_mask) | (avs_writedata & be_mask))
		: trig;

	// ****************************************
	// interrupt status, read clears
	// ****************************************
	wire imst_ev_t stat_ev = {trig_wr, |miss_set};
	wire stat_rd = do_rd & sel_stat;
	wire imst_ev_t next_stat = (stat_rd ? 2'h0 : stat) | stat_ev;
	wire imst_ev_t next_mask = (do_wr & sel_mask & avs_byteenable[0]) ? avs_writedata[1:0] : mask;

	wire imst_word_t rd_mux = sel_flag ? flag :
		sel_miss ? (miss & `IMST_MISS_USED) :
		sel_trig ? trig :
		sel_stat ? {14'h0000, stat} :
		sel_mask ? {14'h0000, mask} : 16'h0000;

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			miss <= `IMST_RST_MISS;
			flag <= `IMST_RST_FLAG;
			trig <= `IMST_RST_TRIG;
			stat <= `IMST_RST_STAT;
			mask <= `IMST_RST_MASK;
		end else begin
			miss <= next_miss & `IMST_MISS_USED;
			flag <= next_flag;
			trig <= next_trig;
			stat <= next_stat;
			mask <= next_mask;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 16'h0000;
			soft_irq_source <= 1'b0;
			pending_flags <= 16'h0000;
			irq <= 1'b0;
		end else begin
			ack <= req;
			avs_waitrequest <= ~req;
			avs_readdata <= do_rd ? rd_mux : 16'h0000;
			soft_irq_source <= trig_wr;
			pending_flags <= next_flag;
			irq <= |(next_stat & mask);
		end
	end
endmodule

// *** dv/imst_top_properties.sv ***
// port assertions of the interrupt miss block
`include "imst_cfg.svh"
module imst_chk (
	// clock and bus
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [15:0] avs_readdata,
	input wire logic avs_waitrequest,
	// sources and results
	input wire imst_pkg::imst_word_t source_event,
	input wire imst_pkg::imst_word_t pending_flags,
	input wire logic soft_irq_source
);
	import imst_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire req = avs_read | avs_write;
	wire ack = req & !avs_waitrequest;
	a_ack_next: assert property (req && avs_waitrequest |=> ack) else $error("no ack");
	a_ack_single: assert property (ack |=> avs_waitrequest) else $error("long ack");
	a_idle_wait: assert property (!req |=> avs_waitrequest) else $error("stray ack");
	a_miss_zero: assert property (ack && avs_read && avs_address == `IMST_MISS_IDX
		|-> !avs_readdata[0]) else $error("bit0 set");
	a_trig_pulse: assert property (ack && avs_write && avs_address == `IMST_TRIG_IDX
		|-> ##[0:2] soft_irq_source) else $error("no pulse");
	a_soft_once: assert property (soft_irq_source |=> !soft_irq_source)
		else $error("long pulse");
	a_soft_pend: assert property (soft_irq_source |-> ##[0:4] pending_flags[1])
		else $error("no sw pend");
	a_event_pend: assert property ($rose(source_event[13]) |-> ##[1:4] pending_flags[13])
		else $error("no pend");
endmodule
bind imst_top imst_chk imst_chk_i (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .source_event, .pending_flags, .soft_irq_source);

// *** dv/imst_src_model.sv ***
// model of the interrupt sources facing the block
module imst_src_model (
	// command
	input wire logic clk,
	input wire logic [15:0] fire,
	// source levels
	output logic [15:0] source_event
);
	timeunit 1ns;
	timeprecision 1ps;
	initial source_event = 16'h0000;
	// held four cycles so the two-flop sync cannot miss it
	always @(posedge clk) if (|fire) begin
		source_event <= fire;
		repeat (4) @(posedge clk);
		source_event <= 16'h0000;
	end
endmodule

// *** dv/imst_top_tb_top.sv ***
// bench of the interrupt miss block
`include "imst_cfg.svh"
module imst_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, app_mode = 0;
	logic [15:0] avs_address = 0, avs_writedata = 0, fire = 0, q;
	logic [1:0] avs_byteenable = 0;
	wire [15:0] avs_readdata, pending_flags, source_event;
	wire avs_waitrequest, soft_irq_source, irq;
	int err_total = 0, comparisons = 0;
	always #4 clk = ~clk;
	imst_top imst_top_i (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .app_mode, .source_event,
		.pending_flags, .soft_irq_source, .irq);
	imst_src_model imst_src_model_i (.clk, .fire, .source_event);
	task end_of_test;
		$display("errors %0d checks %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(string n, logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", n, e, g);
			err_total++;
		end
	endtask
	task bus(logic w, logic [15:0] a, d, logic [1:0] b = 2'h3);
		@(posedge clk);
		{avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} <= {w, !w, a, d, b};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		{avs_write, avs_read} <= 2'h0;
	endtask
	task rd(logic [15:0] a, e);
		bus(0, a, 0);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task t_reset;
		logic [15:0] regs[6] = '{16'h4600, 16'h4602, 16'h4638, 16'h4640, 16'h4642, 16'h4700};
		bus(1, 16'h4700, 16'hFFFF);
		foreach (regs[i]) rd(regs[i], 16'h0000);
		$display("t_reset done");
	endtask
	task t_miss;
		bus(1, `IMST_MISS_IDX, 16'hFFFF);
		rd(`IMST_MISS_IDX, 16'hFFFE);
		bus(1, `IMST_FLAG_IDX, 16'hFFFF);
		app_mode <= 1;
		repeat (3) @(posedge clk);
		bus(1, `IMST_MISS_IDX, 16'h0000);
		rd(`IMST_MISS_IDX, 16'hC79E);
		bus(1, `IMST_FLAG_IDX, 16'h0000);
		rd(`IMST_FLAG_IDX, 16'h0010);
		app_mode <= 0;
		repeat (3) @(posedge clk);
		bus(1, `IMST_MISS_IDX, 16'h0000);
		bus(1, `IMST_FLAG_IDX, 16'h0000);
		$display("t_miss done");
	endtask
	task t_event;
		for (int i = 0; i < 2; i++) begin
			fire <= 16'h2000;
			@(posedge clk);
			fire <= 16'h0000;
			repeat (10) @(posedge clk);
			rd(`IMST_MISS_IDX, i ? 16'h2000 : 16'h0000);
		end
		rd(`IMST_FLAG_IDX, 16'h2000);
		chk("irq", 16'h0000, {15'h0, irq});
		bus(1, `IMST_MASK_IDX, 16'h0001);
		repeat (2) @(posedge clk);
		chk("irq", 16'h0001, {15'h0, irq});
		bus(1, `IMST_MISS_IDX, 16'h0000);
		bus(1, `IMST_FLAG_IDX, 16'h0000);
		rd(`IMST_STAT_IDX, 16'h0001);
		repeat (2) @(posedge clk);
		chk("irq", 16'h0000, {15'h0, irq});
		$display("t_event done");
	endtask
	task t_trig;
		bus(1, `IMST_TRIG_IDX, 16'hA5A5, 2'h2);
		rd(`IMST_TRIG_IDX, 16'hA500);
		rd(`IMST_FLAG_IDX, 16'h0002);
		rd(`IMST_STAT_IDX, 16'h0002);
		$display("t_trig done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1;
		t_reset;
		t_miss;
		t_event;
		t_trig;
		end_of_test;
	end
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		end_of_test;
	end
endmodule
